// ---- stw_pkg.sv ----
/*
 the package holds the register map, field positions, reset values, state
 codes and timing constants for the supervisor.
 assumes a 20 MHz clock.
*/
package stw_pkg;
  localparam int unsigned CLK_HZ = 20000000;

  // register indices
  localparam logic [3:0] REG_HV_ON   = 4'h3;
  localparam logic [3:0] REG_HV_OFF  = 4'h4;
  localparam logic [3:0] REG_LV_PRI  = 4'h5;
  localparam logic [3:0] REG_LV_SEC  = 4'h6;
  localparam logic [3:0] REG_RST_CFG = 4'hD;
  localparam logic [3:0] REG_WD_CFG  = 4'hF;

  // reset values (neutral picks where none is given)
  localparam logic [7:0] HV_ON_RST   = 8'h08;
  localparam logic [7:0] HV_OFF_RST  = 8'h06;
  localparam logic [7:0] LV_PRI_RST  = 8'h00;
  localparam logic [7:0] LV_SEC_RST  = 8'h00;
  // [7:5] reset hold sel, [3] secondary block, [2:0] sd hold sel
  localparam logic [7:0] RST_CFG_RST = 8'h0B;
  // [7:5] wd timeout sel, [3] wd mode, [2:0] sd delay sel
  localparam logic [7:0] WD_CFG_RST  = 8'hC3;

  // field positions
  localparam int unsigned SEC_BLOCK_BIT = 3;
  localparam int unsigned WD_MODE_BIT   = 3;
  localparam int unsigned RH_SEL_LSB    = 5;
  localparam int unsigned WD_SEL_LSB    = 5;
  localparam int unsigned SD_SEL_LSB    = 0;
  localparam logic [3:0]  EDGE_MODE_CODE = 4'h9;

  // fault register bits
  localparam int unsigned FLT_HV_OFF = 0;
  localparam int unsigned FLT_HV_ON  = 1;

  // times in microseconds, eight steps each
  typedef int unsigned tbl_t [8];
  localparam tbl_t SD_HOLD_US  = '{70, 1000, 5000, 10000, 20000, 50000, 100000, 200000};
  localparam tbl_t SD_DELAY_US = '{70, 10000, 50000, 100000, 200000, 400000, 800000, 1200000};
  localparam tbl_t RS_HOLD_US  = '{100, 1000, 5000, 10000, 20000, 50000, 100000, 200000};
  localparam tbl_t WD_TMO_US   = '{100000, 200000, 400000, 600000, 800000, 1000000, 1500000, 2000000};
  localparam int unsigned US_CYC = CLK_HZ / 1000000;

  // glitch filter and warning delay
  localparam int unsigned GLITCH_US    = 30;
  localparam int unsigned GLITCH_CYC   = GLITCH_US * US_CYC;
  localparam int unsigned WARN_PROP_US = 20;
  localparam int unsigned WARN_CYC     = WARN_PROP_US * US_CYC;

  localparam int unsigned CW = 26;

  typedef enum logic [2:0] {
    SD_IDLE  = 3'b001,
    SD_DELAY = 3'b010,
    SD_HOLD  = 3'b100
  } stw_sd_t;

  typedef enum logic [2:0] {
    WD_OFF   = 3'b001,
    WD_WATCH = 3'b010,
    WD_PULSE = 3'b100
  } stw_wd_t;
endpackage

// ---- stw_supervisor.sv ----
/*
 supervisor timers and watchdog: shutdown, warning and reset sequencing
 from digitised comparator results, plus a standard-mode watchdog.
 assumes comparator outcomes and the register port are synchronous to clk.
*/
`timescale 1ns/1ps
module stw_supervisor #(
  parameter int unsigned GLITCH_CYCLES = stw_pkg::GLITCH_CYC,
  parameter int unsigned WARN_CYCLES   = stw_pkg::WARN_CYC,
  parameter int unsigned US_CYCLES     = stw_pkg::US_CYC
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       hv_on_cmp,
  input  wire logic       hv_off_cmp,
  input  wire logic       lv_primary_uv,
  input  wire logic       lv_secondary_uv,
  input  wire logic       watchdog_kick_in,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [3:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  output logic      [7:0] hv_on_level,
  output logic      [7:0] hv_off_level,
  output logic      [7:0] lv_primary_level,
  output logic      [7:0] lv_secondary_level,
  output logic            shutdown_out_n,
  output logic            early_warning_n,
  output logic            reset_out_n,
  output logic            aux_comparator_out,
  output logic      [7:0] fault_status
);
  // elaboration checks on the counts
  if (GLITCH_CYCLES < 1 || WARN_CYCLES < 1 || US_CYCLES < 1) begin : g_bad_cnt
    $error("stw_supervisor: counts must be at least one");
  end
  // longest table entry must fit the shared counters
  if (64'(stw_pkg::SD_DELAY_US[7]) * 64'(US_CYCLES) >= (64'h1 << stw_pkg::CW) ||
      64'(stw_pkg::WD_TMO_US[7]) * 64'(US_CYCLES) >= (64'h1 << stw_pkg::CW) ||
      64'(GLITCH_CYCLES) >= (64'h1 << stw_pkg::CW) ||
      64'(WARN_CYCLES) >= (64'h1 << stw_pkg::CW)) begin : g_bad_width
    $error("stw_supervisor: counter width too small for the timing tables");
  end

  localparam int unsigned CW = stw_pkg::CW;

  typedef struct packed {
    logic [7:0]       on_q;
    logic [7:0]       off_q;
    logic [7:0]       pri_q;
    logic [7:0]       sec_q;
    logic [7:0]       rcfg_q;
    logic [7:0]       wcfg_q;
    logic [7:0]       flt_q;
    logic [7:0]       rdata_q;
    logic [CW-1:0]    glt_q;
    logic             fault_q;
    stw_pkg::stw_sd_t sd_q;
    logic [CW-1:0]    sd_cnt_q;
    logic             sd_n_q;
    logic             warn_n_q;
    logic             lv_act_q;
    logic [CW-1:0]    rh_cnt_q;
    logic             rst_n_q;
    stw_pkg::stw_wd_t wd_q;
    logic [CW-1:0]    wd_cnt_q;
    logic             kick_q;
    logic             aux_q;
  } stw_state_t;

  stw_state_t s_q;
  stw_state_t s_d;

  function automatic logic [CW-1:0] cyc_of(input int unsigned us);
    cyc_of = CW'(us * US_CYCLES);
  endfunction

  function automatic logic [2:0] fld3(input logic [7:0] r, input int unsigned lsb);
    fld3 = r[lsb +: 3];
  endfunction

  logic          edge_mode;
  logic          hv_bad;
  logic          hv_off_hit;
  logic          hv_fault;
  logic          lv_bad;
  logic          kicked;
  logic [CW-1:0] sd_delay_cyc;
  logic [CW-1:0] sd_hold_cyc;
  logic [CW-1:0] rs_hold_cyc;
  logic [CW-1:0] wd_tmo_cyc;

  always_comb begin
    edge_mode    = (s_q.off_q[3:0] == stw_pkg::EDGE_MODE_CODE);
    hv_off_hit   = ~edge_mode & hv_off_cmp;
    hv_bad       = ~hv_on_cmp | hv_off_hit;
    lv_bad       = lv_primary_uv | (lv_secondary_uv & ~s_q.rcfg_q[stw_pkg::SEC_BLOCK_BIT]);
    kicked       = watchdog_kick_in ^ s_q.kick_q;
    hv_fault     = s_q.fault_q;
    sd_delay_cyc = cyc_of(stw_pkg::SD_DELAY_US[fld3(s_q.wcfg_q, stw_pkg::SD_SEL_LSB)]);
    sd_hold_cyc  = cyc_of(stw_pkg::SD_HOLD_US[fld3(s_q.rcfg_q, stw_pkg::SD_SEL_LSB)]);
    rs_hold_cyc  = cyc_of(stw_pkg::RS_HOLD_US[fld3(s_q.rcfg_q, stw_pkg::RH_SEL_LSB)]);
    wd_tmo_cyc   = cyc_of(stw_pkg::WD_TMO_US[fld3(s_q.wcfg_q, stw_pkg::WD_SEL_LSB)]);
  end

  always_comb begin
    s_d = s_q;
    s_d.kick_q = watchdog_kick_in;
    s_d.aux_q  = ~lv_secondary_uv;

    // register writes
    if (reg_wr) begin
      case (reg_addr)
        stw_pkg::REG_HV_ON:   s_d.on_q = reg_wdata;
        stw_pkg::REG_HV_OFF:  s_d.off_q = reg_wdata;
        stw_pkg::REG_LV_PRI:  s_d.pri_q = reg_wdata;
        stw_pkg::REG_LV_SEC:  s_d.sec_q = reg_wdata;
        stw_pkg::REG_RST_CFG: s_d.rcfg_q = reg_wdata;
        stw_pkg::REG_WD_CFG:  s_d.wcfg_q = reg_wdata;
        default: begin
        end
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        stw_pkg::REG_HV_ON:   s_d.rdata_q = s_q.on_q;
        stw_pkg::REG_HV_OFF:  s_d.rdata_q = s_q.off_q;
        stw_pkg::REG_LV_PRI:  s_d.rdata_q = s_q.pri_q;
        stw_pkg::REG_LV_SEC:  s_d.rdata_q = s_q.sec_q;
        stw_pkg::REG_RST_CFG: s_d.rdata_q = s_q.rcfg_q;
        stw_pkg::REG_WD_CFG:  s_d.rdata_q = s_q.wcfg_q;
        default:              s_d.rdata_q = 8'h00;
      endcase
    end

    // glitch filter
    if (!hv_bad) begin
      s_d.glt_q   = '0;
      s_d.fault_q = 1'b0;
    end else if (s_q.glt_q >= CW'(GLITCH_CYCLES)) begin
      s_d.fault_q = 1'b1;
    end else begin
      s_d.glt_q = s_q.glt_q + CW'(1);
    end

    // shutdown sequencer
    case (s_q.sd_q)
      stw_pkg::SD_IDLE: begin
        s_d.sd_n_q = 1'b1;
        if (hv_fault) begin
          s_d.sd_q     = stw_pkg::SD_DELAY;
          s_d.sd_cnt_q = '0;
          s_d.warn_n_q = 1'b0;
          if (hv_off_hit) begin
            s_d.flt_q[stw_pkg::FLT_HV_OFF] = 1'b1;
          end else begin
            s_d.flt_q[stw_pkg::FLT_HV_ON] = 1'b1;
          end
        end
      end
      stw_pkg::SD_DELAY: begin
        s_d.sd_cnt_q = s_q.sd_cnt_q + CW'(1);
        if (!hv_fault) begin
          s_d.sd_q     = stw_pkg::SD_IDLE;
          s_d.warn_n_q = 1'b1;
        end else if (s_q.sd_cnt_q + CW'(1) >= sd_delay_cyc && s_q.sd_cnt_q + CW'(1) >= CW'(WARN_CYCLES)) begin
          s_d.sd_q     = stw_pkg::SD_HOLD;
          s_d.sd_n_q   = 1'b0;
          s_d.sd_cnt_q = '0;
        end
      end
      stw_pkg::SD_HOLD: begin
        s_d.sd_n_q = 1'b0;
        if (hv_fault) begin
          s_d.sd_cnt_q = '0;
        end else if (s_q.sd_cnt_q + CW'(1) >= sd_hold_cyc) begin
          s_d.sd_q     = stw_pkg::SD_IDLE;
          s_d.sd_n_q   = 1'b1;
          s_d.warn_n_q = 1'b1;
        end else begin
          s_d.sd_cnt_q = s_q.sd_cnt_q + CW'(1);
        end
      end
      default: s_d.sd_q = stw_pkg::SD_IDLE;
    endcase

    // low-voltage reset hold
    if (lv_bad) begin
      s_d.lv_act_q = 1'b1;
      s_d.rh_cnt_q = '0;
    end else if (s_q.lv_act_q) begin
      if (s_q.rh_cnt_q + CW'(1) >= rs_hold_cyc) begin
        s_d.lv_act_q = 1'b0;
      end else begin
        s_d.rh_cnt_q = s_q.rh_cnt_q + CW'(1);
      end
    end

    // watchdog
    case (s_q.wd_q)
      stw_pkg::WD_OFF: begin
        s_d.wd_cnt_q = '0;
        if (s_q.rst_n_q) begin
          s_d.wd_q = stw_pkg::WD_WATCH;
        end
      end
      stw_pkg::WD_WATCH: begin
        if (!s_q.rst_n_q) begin
          s_d.wd_q     = stw_pkg::WD_OFF;
          s_d.wd_cnt_q = '0;
        end else if (kicked) begin
          s_d.wd_cnt_q = '0;
        end else if (s_q.wd_cnt_q + CW'(1) >= wd_tmo_cyc) begin
          s_d.wd_q     = stw_pkg::WD_PULSE;
          s_d.wd_cnt_q = '0;
        end else begin
          s_d.wd_cnt_q = s_q.wd_cnt_q + CW'(1);
        end
      end
      stw_pkg::WD_PULSE: begin
        if (s_q.wd_cnt_q + CW'(1) >= rs_hold_cyc) begin
          s_d.wd_q     = stw_pkg::WD_WATCH;
          s_d.wd_cnt_q = '0;
        end else begin
          s_d.wd_cnt_q = s_q.wd_cnt_q + CW'(1);
        end
      end
      default: s_d.wd_q = stw_pkg::WD_OFF;
    endcase

    s_d.rst_n_q = s_d.sd_n_q & ~s_d.lv_act_q & (s_d.wd_q != stw_pkg::WD_PULSE);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_q          <= '0;
      s_q.on_q     <= stw_pkg::HV_ON_RST;
      s_q.off_q    <= stw_pkg::HV_OFF_RST;
      s_q.pri_q    <= stw_pkg::LV_PRI_RST;
      s_q.sec_q    <= stw_pkg::LV_SEC_RST;
      s_q.rcfg_q   <= stw_pkg::RST_CFG_RST;
      s_q.wcfg_q   <= stw_pkg::WD_CFG_RST;
      s_q.sd_q     <= stw_pkg::SD_HOLD;
      s_q.warn_n_q <= 1'b0;
      s_q.wd_q     <= stw_pkg::WD_OFF;
    end else begin
      s_q <= s_d;
    end
  end

  always_comb begin
    reg_rdata          = s_q.rdata_q;
    hv_on_level        = s_q.on_q;
    hv_off_level       = s_q.off_q;
    lv_primary_level   = s_q.pri_q;
    lv_secondary_level = s_q.sec_q;
    shutdown_out_n     = s_q.sd_n_q;
    early_warning_n    = s_q.warn_n_q;
    reset_out_n        = s_q.rst_n_q;
    aux_comparator_out = s_q.aux_q;
    fault_status       = s_q.flt_q;
  end
endmodule

// ---- stw_checker.sv ----
/* assertions on the supervisor ports.
 assumes one clock and rst async active high. */
`timescale 1ns/1ps
module stw_checker #(
  parameter int unsigned GLITCH_CYCLES = stw_pkg::GLITCH_CYC,
  parameter int unsigned WARN_CYCLES   = stw_pkg::WARN_CYC,
  parameter int unsigned US_CYCLES     = stw_pkg::US_CYC
) (
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       hv_on_cmp,
  input wire logic       hv_off_cmp,
  input wire logic       lv_primary_uv,
  input wire logic       lv_secondary_uv,
  input wire logic       shutdown_out_n,
  input wire logic       early_warning_n,
  input wire logic       reset_out_n,
  input wire logic       aux_comparator_out,
  input wire logic [7:0] fault_status
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic [15:0] flt_q;
  logic [15:0] low_q;
  // run lengths of fault and of shutdown low
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flt_q <= 16'h0000;
      low_q <= 16'h0000;
    end else begin
      flt_q <= (!hv_on_cmp || hv_off_cmp) ? flt_q + 16'h0001 : 16'h0000;
      low_q <= !shutdown_out_n ? low_q + 16'h0001 : 16'h0000;
    end
  end
  property p_warn_first; $fell(shutdown_out_n) |-> !$past(early_warning_n); endproperty
  a_warn_first: assert property (p_warn_first) else $error("shutdown without warning");
  property p_warn_clr; $rose(shutdown_out_n) |-> early_warning_n; endproperty
  a_warn_clr: assert property (p_warn_clr) else $error("warning low at release");
  property p_rst_sd; $fell(shutdown_out_n) |-> !reset_out_n; endproperty
  a_rst_sd: assert property (p_rst_sd) else $error("reset not with shutdown");
  property p_rst_rel; $rose(reset_out_n) |-> shutdown_out_n; endproperty
  a_rst_rel: assert property (p_rst_rel) else $error("reset freed in shutdown");
  property p_glitch; $fell(early_warning_n) |-> flt_q >= GLITCH_CYCLES; endproperty
  a_glitch: assert property (p_glitch) else $error("warning before filter");
  property p_hold; $rose(shutdown_out_n) |-> low_q >= 70 * US_CYCLES; endproperty
  a_hold: assert property (p_hold) else $error("shutdown hold short");
  property p_aux; !$past(rst) |-> aux_comparator_out == !$past(lv_secondary_uv); endproperty
  a_aux: assert property (p_aux) else $error("aux output wrong");
  property p_uv; lv_primary_uv |-> ##[1:3] !reset_out_n; endproperty
  a_uv: assert property (p_uv) else $error("undervoltage without reset");
  property p_sticky; fault_status[0] |=> fault_status[0]; endproperty
  a_sticky: assert property (p_sticky) else $error("fault bit lost");
  c_sd: cover property ($fell(shutdown_out_n));
  c_warn: cover property ($fell(early_warning_n));
  c_rst: cover property ($rose(reset_out_n));
endmodule
bind stw_supervisor stw_checker #(.GLITCH_CYCLES(GLITCH_CYCLES), .WARN_CYCLES(WARN_CYCLES),
  .US_CYCLES(US_CYCLES)) i_chk (.clk(clk), .rst(rst), .hv_on_cmp(hv_on_cmp), .hv_off_cmp(hv_off_cmp),
  .lv_primary_uv(lv_primary_uv), .lv_secondary_uv(lv_secondary_uv), .shutdown_out_n(shutdown_out_n),
  .early_warning_n(early_warning_n), .reset_out_n(reset_out_n), .aux_comparator_out(aux_comparator_out),
  .fault_status(fault_status));

// ---- stw_proc.sv ----
/* processor model: toggles the kick line at a steady rate.
 assumes kick_en from the bench. */
`timescale 1ns/1ps
module stw_proc #(
  parameter int KICK = 500
) (
  input  wire logic clk,
  input  wire logic kick_en,
  output logic      watchdog_kick_in
);
  int cnt = 0;
  initial watchdog_kick_in = 1'b0;
  always @(negedge clk) begin
    cnt <= (cnt == KICK - 1) ? 0 : cnt + 1;
    if (kick_en && cnt == 0) begin
      watchdog_kick_in <= !watchdog_kick_in;
    end
  end
endmodule

// ---- tb.sv ----
/* self-checking bench for the supervisor with a register model.
 assumes US_CYCLES 1 so table entries are cycles. */
`timescale 1ns/1ps
module tb;
  localparam int GC = 8;
  logic        clk = 1'b0, rst = 1'b1, hv_on_cmp = 1'b1, hv_off_cmp = 1'b0;
  logic        lv_primary_uv = 1'b0, lv_secondary_uv = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, kick_en = 1'b1;
  logic [3:0]  reg_addr = 4'h0;
  logic [7:0]  reg_wdata = 8'h00, reg_rdata, on_l, off_l, p_l, s_l, fault_status;
  logic        shutdown_out_n, early_warning_n, reset_out_n, aux_comparator_out, watchdog_kick_in;
  int          err_count = 0, n_tests = 0, cyc = 0, n;
  logic [31:0] seed = 32'h00007FBF;
  logic [7:0]  regm [16];
  stw_supervisor #(.GLITCH_CYCLES(GC), .WARN_CYCLES(4), .US_CYCLES(1)) i_dut (.clk(clk), .rst(rst),
    .hv_on_cmp(hv_on_cmp), .hv_off_cmp(hv_off_cmp), .lv_primary_uv(lv_primary_uv),
    .lv_secondary_uv(lv_secondary_uv), .watchdog_kick_in(watchdog_kick_in), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .hv_on_level(on_l), .hv_off_level(off_l),
    .lv_primary_level(p_l), .lv_secondary_level(s_l), .shutdown_out_n(shutdown_out_n),
    .early_warning_n(early_warning_n), .reset_out_n(reset_out_n), .aux_comparator_out(aux_comparator_out),
    .fault_status(fault_status));
  stw_proc i_proc (.clk(clk), .kick_en(kick_en), .watchdog_kick_in(watchdog_kick_in));
  always #25 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc > 20000) begin
      err_count++;
      end_sim();
    end
  end
  task automatic end_sim();
    $display("errors %0d checks %0d", err_count, n_tests);
    if (err_count == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s exp %0h seen %0h", nm, exp, seen);
    end
  endtask
  task automatic ct(input string nm, input int e);
    chk(nm, (n + 1 >= e) && (n <= e + 3), 1'b1);
  endtask
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk);
    reg_wr = 1'b0;
    if (a inside {4'h3, 4'h4, 4'h5, 4'h6, 4'hD, 4'hF}) regm[a] = d;
  endtask
  task automatic rd(input logic [3:0] a);
    @(negedge clk);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge clk);
    reg_rd = 1'b0;
    chk("rdata", reg_rdata, regm[a]);
  endtask
  function automatic logic sig(input int w);
    case (w)
      0: return shutdown_out_n;
      1: return early_warning_n;
      default: return reset_out_n;
    endcase
  endfunction
  task automatic wt(input int w, input logic v, input int lim);
    n = 0;
    while (sig(w) !== v && n < lim) begin
      @(negedge clk);
      n++;
    end
  endtask
  initial begin
    regm = '{default: 8'h00};
    regm[3] = stw_pkg::HV_ON_RST;
    regm[4] = stw_pkg::HV_OFF_RST;
    regm[13] = stw_pkg::RST_CFG_RST;
    regm[15] = stw_pkg::WD_CFG_RST;
    repeat (4) @(posedge clk);
    #1 chk("in_rst", {shutdown_out_n, reset_out_n}, 2'b00);
    @(negedge clk);
    rst = 1'b0;
    wt(0, 1'b1, 12000);
    ct("hold_dflt", stw_pkg::SD_HOLD_US[3]);
    chk("rst_rel", reset_out_n, 1'b1);
    for (int a = 0; a < 16; a++) rd(a[3:0]);
    wr(4'h3, 8'(8'h08 + xs() % 8));
    wr(4'h5, 8'(xs()));
    wr(4'h6, 8'(xs()));
    wr(4'h7, 8'(xs()));
    rd(4'h7);
    chk("levels", {on_l, off_l, p_l, s_l}, {regm[3], regm[4], regm[5], regm[6]});
    wr(4'hD, 8'h00);
    wr(4'hF, 8'h00);
    hv_off_cmp = 1'b1;
    repeat (GC) @(negedge clk);
    hv_off_cmp = 1'b0;
    wt(1, 1'b0, 30);
    chk("glitch", n, 30);
    hv_off_cmp = 1'b1;
    wt(1, 1'b0, 50);
    ct("warn_t", GC + 1);
    wt(0, 1'b0, 300);
    ct("sd_delay", stw_pkg::SD_DELAY_US[0] > 4 ? stw_pkg::SD_DELAY_US[0] : 4);
    chk("rst_sd", reset_out_n, 1'b0);
    chk("flt_off", fault_status[stw_pkg::FLT_HV_OFF], 1'b1);
    hv_off_cmp = 1'b0;
    wt(0, 1'b1, 300);
    ct("sd_hold", stw_pkg::SD_HOLD_US[0]);
    chk("rel", {reset_out_n, early_warning_n}, 2'b11);
    wr(4'h4, {4'h0, stw_pkg::EDGE_MODE_CODE});
    hv_off_cmp = 1'b1;
    wt(1, 1'b0, 40);
    chk("edge_off", n, 40);
    hv_on_cmp = 1'b0;
    wt(0, 1'b0, 300);
    chk("edge_on", fault_status[stw_pkg::FLT_HV_ON], 1'b1);
    hv_on_cmp = 1'b1;
    hv_off_cmp = 1'b0;
    wt(0, 1'b1, 300);
    wr(4'h4, 8'h06);
    lv_primary_uv = 1'b1;
    wt(2, 1'b0, 5);
    chk("uv1", n <= 3, 1'b1);
    lv_primary_uv = 1'b0;
    wt(2, 1'b1, 400);
    ct("uv1_hold", stw_pkg::RS_HOLD_US[0]);
    lv_secondary_uv = 1'b1;
    wt(2, 1'b0, 5);
    chk("uv2", n <= 3, 1'b1);
    lv_secondary_uv = 1'b0;
    wt(2, 1'b1, 400);
    ct("uv2_hold", stw_pkg::RS_HOLD_US[0]);
    wr(4'hD, 8'h08);
    lv_secondary_uv = 1'b1;
    wt(2, 1'b0, 20);
    chk("uv2_blk", n, 20);
    chk("aux", aux_comparator_out, 1'b0);
    lv_secondary_uv = 1'b0;
    wt(2, 1'b0, 2000);
    chk("wd_kick", n, 2000);
    end_sim();
  end
endmodule
